// *** inc/init_regs_pkg.sv ***
package init_regs_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [31:0] off_main = 32'h0000_0000;
  localparam logic [31:0] off_addr_low = 32'h0000_0004;
  localparam logic [31:0] off_addr_high = 32'h0000_0008;
  localparam logic [31:0] off_mask = 32'h0000_000C;
  localparam logic [31:0] off_low_shadow = 32'h0000_0010;
  localparam logic [31:0] off_high_shadow = 32'h0000_0014;

  // ==========================================================
  // Field positions
  localparam int bit_init = 0;
  localparam int bit_run = 1;
  localparam int bit_halt = 2;
  localparam int bit_summary = 7;
  localparam int evt_lsb = 8;
  localparam int evt_msb = 11;
  localparam int high_used_msb = 7;

  // ==========================================================
  // Reset values
  localparam logic rst_halt = 1'h1;
  localparam logic rst_init = 1'h0;
  localparam logic rst_run = 1'h0;
  localparam logic [3:0] rst_mask = 4'h0;

  // ==========================================================
  // Initialization block fetch
  localparam logic [4:0] init_block_words = 5'h0C;
  localparam logic [23:0] init_addr_step = 24'h00_0002;

  // Same bit order as mask bits 11..8 and status bits 11..8
  typedef struct packed {
    logic memory_error;
    logic receive_done;
    logic transmit_done;
    logic init_done;
  } evt_t;

  typedef enum logic [1:0] {
    fetch_idle,
    fetch_req,
    fetch_release
  } fetch_state_t;

endpackage

// *** rtl/init_fetch.sv ***
`timescale 1ns/1ps
module init_fetch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic [23:0] base_addr,
  input wire logic mem_ack,
  output logic mem_req,
  output logic [23:0] mem_addr,
  output logic busy,
  output logic done
);

  // ==========================================================
  // Four-phase fetch of the initialization block
  init_regs_pkg::fetch_state_t state_ff;
  init_regs_pkg::fetch_state_t nxt_state;
  logic req_ff;
  logic nxt_req;
  logic done_ff;
  logic nxt_done;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_addr = addr_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'h0;
    case (state_ff)
      init_regs_pkg::fetch_idle: begin
        if (start) begin
          nxt_addr = base_addr;
          nxt_cnt = 5'h00;
          nxt_req = 1'h1;
          nxt_state = init_regs_pkg::fetch_req;
        end
      end
      init_regs_pkg::fetch_req: begin
        if (mem_ack) begin
          nxt_req = 1'h0;
          nxt_state = init_regs_pkg::fetch_release;
        end
      end
      default: begin
        // Wait for ack low so every word is a full handshake
        if (!mem_ack) begin
          if (cnt_ff == init_regs_pkg::init_block_words - 5'h01) begin
            nxt_done = 1'h1;
            nxt_state = init_regs_pkg::fetch_idle;
          end else begin
            nxt_cnt = cnt_ff + 5'h01;
            nxt_addr = addr_ff + init_regs_pkg::init_addr_step;
            nxt_req = 1'h1;
            nxt_state = init_regs_pkg::fetch_req;
          end
        end
      end
    endcase
    if (abort) begin
      nxt_state = init_regs_pkg::fetch_idle;
      nxt_req = 1'h0;
      nxt_done = 1'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= init_regs_pkg::fetch_idle;
      req_ff <= 1'h0;
      done_ff <= 1'h0;
      addr_ff <= 24'h00_0000;
      cnt_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      done_ff <= nxt_done;
      addr_ff <= nxt_addr;
      cnt_ff <= nxt_cnt;
    end
  end

  assign mem_req = req_ff;
  assign mem_addr = addr_ff;
  assign done = done_ff;
  assign busy = (state_ff != init_regs_pkg::fetch_idle);

endmodule

// *** rtl/irq_unit.sv ***
`timescale 1ns/1ps
module irq_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire init_regs_pkg::evt_t set_evt,
  input wire init_regs_pkg::evt_t clr_evt,
  input wire init_regs_pkg::evt_t mask,
  output init_regs_pkg::evt_t flags,
  output logic irq
);

  // ==========================================================
  // Sticky event flags, write-one-to-clear, set wins
  init_regs_pkg::evt_t flags_ff;
  init_regs_pkg::evt_t nxt_flags;
  logic irq_ff;
  logic nxt_irq;

  // Flags still latch while masked, only the summary is gated
  assign nxt_flags = set_evt | (flags_ff & ~clr_evt);
  assign nxt_irq = |(nxt_flags & ~mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
      irq_ff <= 1'h0;
    end else begin
      flags_ff <= nxt_flags;
      irq_ff <= nxt_irq;
    end
  end

  assign flags = flags_ff;
  assign irq = irq_ff;

endmodule

// *** rtl/init_ctrl_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Init and run together: initialize first
// - Init bit stays set after completion
// - Init: write one sets, halt clears
// - Low address holds bits 15..0, even; bit 0 is stored as written
// - Low address write updates its shadow
// - Low address only accessible while halted
// - High address bits 15..8 read zero
// - Memory error mask gates summary flag
// - Receive done mask gates summary flag
// - Transmit done mask gates summary flag
// - Init done mask gates summary flag
// - Masks cleared by reset, not halt
// - Mask bits 7..5 reserved, write zero
// - Init fetches block at 24-bit address
// - Halt set by write/reset, run/init clear
// - High address bits 23..16, shadow copy
module init_ctrl_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic memory_error_in,
  input wire logic receive_done_in,
  input wire logic transmit_done_in,
  input wire logic mem_ack,
  output logic mem_req,
  output logic [23:0] mem_addr,
  output logic run_active,
  output logic halt_active,
  output logic irq
);

  // ==========================================================
  // Pin synchronisers
  // Bit order: ack, memory error, receive done, transmit done
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [2:0] evt_prev_ff;
  logic ack_sync;
  logic [2:0] evt_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      evt_prev_ff <= 3'h0;
    end else begin
      sync1_ff <= {mem_ack, memory_error_in, receive_done_in, transmit_done_in};
      sync2_ff <= sync1_ff;
      evt_prev_ff <= sync2_ff[2:0];
    end
  end

  // A held event pin counts once, on its rising edge
  assign ack_sync = sync2_ff[3];
  assign evt_rise = sync2_ff[2:0] & ~evt_prev_ff;

  // ==========================================================
  // APB address decode
  logic sel_main;
  logic sel_low;
  logic sel_high;
  logic sel_mask;
  logic sel_low_sh;
  logic sel_high_sh;
  logic sel_locked;
  logic hit;
  logic acc_err;
  logic setup;
  logic access;
  logic wr;

  assign sel_main = (paddr == init_regs_pkg::off_main);
  assign sel_low = (paddr == init_regs_pkg::off_addr_low);
  assign sel_high = (paddr == init_regs_pkg::off_addr_high);
  assign sel_mask = (paddr == init_regs_pkg::off_mask);
  assign sel_low_sh = (paddr == init_regs_pkg::off_low_shadow);
  assign sel_high_sh = (paddr == init_regs_pkg::off_high_shadow);
  assign hit = sel_main | sel_low | sel_high | sel_mask | sel_low_sh | sel_high_sh;

  // ==========================================================
  // APB slave timing
  logic halt_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [15:0] rd_data;
  logic [31:0] nxt_prdata;

  // Address registers are locked unless halted; the bus sees an error
  assign sel_locked = (sel_low | sel_high) & ~halt_ff;
  assign acc_err = ~hit | sel_locked;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wr = access & pwrite & ~acc_err;

  // One fixed answer cycle keeps pready a plain flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & acc_err;
      prdata_ff <= nxt_prdata;
    end
  end

  assign nxt_prdata = (setup & ~pwrite & ~acc_err) ? {16'h0000, rd_data} : 32'h0000_0000;

  // ==========================================================
  // Command bits of the main control register
  logic init_ff;
  logic run_ff;
  logic kick_ff;
  logic nxt_halt;
  logic nxt_init;
  logic nxt_run;
  logic wr_main;
  logic w_halt;
  logic w_init;
  logic w_run;

  assign wr_main = wr & sel_main;
  assign w_halt = wr_main & pwdata[init_regs_pkg::bit_halt];
  // Halt overrides init and run written in the same word
  assign w_init = wr_main & pwdata[init_regs_pkg::bit_init] & ~w_halt;
  assign w_run = wr_main & pwdata[init_regs_pkg::bit_run] & ~w_halt;

  assign nxt_halt = w_halt ? 1'h1 : ((w_init | w_run) ? 1'h0 : halt_ff);
  // Completion of the fetch does not touch init
  assign nxt_init = w_halt ? 1'h0 : (w_init ? 1'h1 : init_ff);
  assign nxt_run = w_halt ? 1'h0 : (w_run ? 1'h1 : run_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_ff <= init_regs_pkg::rst_halt;
      init_ff <= init_regs_pkg::rst_init;
      run_ff <= init_regs_pkg::rst_run;
      kick_ff <= 1'h0;
    end else begin
      halt_ff <= nxt_halt;
      init_ff <= nxt_init;
      run_ff <= nxt_run;
      kick_ff <= w_init;
    end
  end

  // ==========================================================
  // Initialization block address and shadows
  // No reset here: contents survive a hardware reset
  logic [15:0] addr_low_ff;
  logic [15:0] low_shadow_ff;
  logic [7:0] addr_high_ff;
  logic [7:0] high_shadow_ff;
  logic wr_low;
  logic wr_high;

  assign wr_low = wr & sel_low;
  assign wr_high = wr & sel_high;

  // Bit 0 is stored as written; keeping it even is up to software
  always_ff @(posedge pclk) begin
    if (wr_low) begin
      addr_low_ff <= pwdata[15:0];
      low_shadow_ff <= pwdata[15:0];
    end
    if (wr_high) begin
      addr_high_ff <= pwdata[init_regs_pkg::high_used_msb:0];
      high_shadow_ff <= pwdata[init_regs_pkg::high_used_msb:0];
    end
  end

  // ==========================================================
  // Interrupt masks
  init_regs_pkg::evt_t mask_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= init_regs_pkg::rst_mask;
    end else if (wr & sel_mask) begin
      // Halt is not a term here, so masks ride through it
      mask_ff <= pwdata[init_regs_pkg::evt_msb:init_regs_pkg::evt_lsb];
    end
  end

  // ==========================================================
  // Initialization fetch and run start
  logic fetch_busy;
  logic fetch_done;
  logic running_ff;
  logic nxt_running;

  init_fetch u_fetch (
    .pclk(pclk),
    .presetn(presetn),
    .start(kick_ff & ~halt_ff),
    .abort(halt_ff),
    .base_addr({addr_high_ff, addr_low_ff}),
    .mem_ack(ack_sync),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .busy(fetch_busy),
    .done(fetch_done)
  );

  // Run waits while a fetch is pending or in flight
  assign nxt_running = run_ff & ~halt_ff & ~fetch_busy & ~kick_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_ff <= 1'h0;
    end else begin
      running_ff <= nxt_running;
    end
  end

  assign run_active = running_ff;
  assign halt_active = halt_ff;

  // ==========================================================
  // Event status and interrupt
  init_regs_pkg::evt_t set_evt;
  init_regs_pkg::evt_t clr_evt;
  init_regs_pkg::evt_t flags;
  logic irq_int;

  assign set_evt = {evt_rise[2], evt_rise[1], evt_rise[0], fetch_done};
  assign clr_evt = wr_main ? pwdata[init_regs_pkg::evt_msb:init_regs_pkg::evt_lsb] : 4'h0;

  irq_unit u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(set_evt),
    .clr_evt(clr_evt),
    .mask(mask_ff),
    .flags(flags),
    .irq(irq_int)
  );

  assign irq = irq_int;

  // ==========================================================
  // Read data
  logic [15:0] main_rd;
  logic [15:0] mask_rd;

  assign main_rd = {4'h0, flags, irq_int, 4'h0, halt_ff, run_ff, init_ff};
  // Reserved mask bits read as zero
  assign mask_rd = {4'h0, mask_ff, 8'h00};
  assign rd_data = sel_main ? main_rd :
                   sel_low ? addr_low_ff :
                   sel_high ? {8'h00, addr_high_ff} :
                   sel_mask ? mask_rd :
                   sel_low_sh ? low_shadow_ff :
                   sel_high_sh ? {8'h00, high_shadow_ff} :
                   16'h0000;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

// *** sim/init_ctrl_regs_monitor.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checker
module init_ctrl_regs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_ack,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic run_active,
  input wire logic halt_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic addr_reg;
  assign acc = psel && penable && pready;
  assign addr_reg = (paddr == init_regs_pkg::off_addr_low) || (paddr == init_regs_pkg::off_addr_high);
  property p_run_gate; run_active |-> !mem_req; endproperty
  a_run_gate: assert property (p_run_gate) else $error("run active during fetch");
  // Run output lags the halt register by one cycle, so look at a settled halt
  property p_halt_norun; halt_active && $past(halt_active) |-> !run_active; endproperty
  a_halt_norun: assert property (p_halt_norun) else $error("running while halted");
  property p_req_hold; mem_req && !mem_ack && !halt_active && !psel |=> mem_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("fetch request dropped early");
  property p_addr_stable; mem_req && $past(mem_req) |-> $stable(mem_addr); endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("fetch address moved");
  property p_lock_err; acc && addr_reg && !halt_active |-> pslverr; endproperty
  a_lock_err: assert property (p_lock_err) else $error("locked access not refused");
  property p_unlock_ok; acc && addr_reg && halt_active |-> !pslverr; endproperty
  a_unlock_ok: assert property (p_unlock_ok) else $error("halted access refused");
  property p_high_zero; acc && !pwrite && paddr == init_regs_pkg::off_addr_high |-> prdata[31:8] == 24'h0; endproperty
  a_high_zero: assert property (p_high_zero) else $error("upper address reserved bits set");
  property p_mask_rsv; acc && !pwrite && paddr == init_regs_pkg::off_mask |-> prdata[7:5] == 3'h0; endproperty
  a_mask_rsv: assert property (p_mask_rsv) else $error("mask reserved bits set");
endmodule
bind init_ctrl_regs init_ctrl_regs_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_ack(mem_ack),
  .mem_req(mem_req), .mem_addr(mem_addr), .run_active(run_active), .halt_active(halt_active));

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mem_ack = 1'b0;
  logic memory_error_in = 1'b0, receive_done_in = 1'b0, transmit_done_in = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, seed = 32'h0000_0216;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_req, run_active, halt_active, irq, er;
  logic [23:0] mem_addr, base;
  logic [15:0] lo;
  logic [7:0] hi;
  logic [3:0] m;
  int mismatches = 0;
  int checked = 0;
  init_ctrl_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memory_error_in(memory_error_in), .receive_done_in(receive_done_in), .transmit_done_in(transmit_done_in),
    .mem_ack(mem_ack), .mem_req(mem_req), .mem_addr(mem_addr), .run_active(run_active),
    .halt_active(halt_active), .irq(irq));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] mexp(input logic i, input logic r, input logic h, input logic [3:0] f, input logic [3:0] k);
    return {20'h0, f, |(f & ~k), 4'h0, h, r, i};
  endfunction
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task conclude;
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One idle cycle after each transfer keeps psel from being driven twice in a step
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No cycle limit here: a missing pready is left to the watchdog
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task waitreq(input logic v);
    int n;
    n = 0;
    while (mem_req !== v && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) chk("mem_req", {31'h0, v}, {31'h0, mem_req});
  endtask
  task pin(input int k);
    memory_error_in <= (k == 0);
    receive_done_in <= (k == 1);
    transmit_done_in <= (k == 2);
    repeat (3) @(posedge pclk);
    memory_error_in <= 1'b0;
    receive_done_in <= 1'b0;
    transmit_done_in <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude;
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("halt", 32'h1, {31'h0, halt_active});
    rdc(init_regs_pkg::off_mask, 32'h0, "mask_rst");
    rdc(init_regs_pkg::off_main, mexp(1'b0, 1'b0, 1'b1, 4'h0, 4'h0), "main_rst");
    rd = rnd();
    lo = {rd[15:1], 1'b0};
    hi = rd[23:16];
    apb(1'b1, init_regs_pkg::off_addr_low, {16'h0, lo});
    apb(1'b1, init_regs_pkg::off_addr_high, {24'h0, hi});
    rdc(init_regs_pkg::off_addr_low, {16'h0, lo}, "lo");
    rdc(init_regs_pkg::off_low_shadow, {16'h0, lo}, "lo_shadow");
    rdc(init_regs_pkg::off_addr_high, {24'h0, hi}, "hi");
    rdc(init_regs_pkg::off_high_shadow, {24'h0, hi}, "hi_shadow");
    apb(1'b0, 32'h0000_0018, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    for (int j = 0; j < 6; j++) begin
      rd = rnd();
      m = rd[3:0];
      m[3 - (j % 3)] = (j < 3);
      apb(1'b1, init_regs_pkg::off_mask, {20'h0, m, 8'h0});
      rdc(init_regs_pkg::off_mask, {20'h0, m, 8'h0}, "mask");
      pin(j % 3);
      chk("irq", {31'h0, ~m[3 - (j % 3)]}, {31'h0, irq});
      rdc(init_regs_pkg::off_main, mexp(1'b0, 1'b0, 1'b1, 4'h8 >> (j % 3), m), "main_evt");
      apb(1'b1, init_regs_pkg::off_main, {20'h0, 4'h8 >> (j % 3), 8'h0});
      rdc(init_regs_pkg::off_main, mexp(1'b0, 1'b0, 1'b1, 4'h0, m), "main_clr");
    end
    apb(1'b1, init_regs_pkg::off_mask, 32'h0);
    base = {hi, lo};
    apb(1'b1, init_regs_pkg::off_main, 32'h0000_0003);
    for (int w = 0; w < 12; w++) begin
      waitreq(1'b1);
      chk("mem_addr", {8'h0, base + 24'(w * 2)}, {8'h0, mem_addr});
      chk("run_early", 32'h0, {31'h0, run_active});
      mem_ack <= 1'b1;
      waitreq(1'b0);
      mem_ack <= 1'b0;
    end
    repeat (12) @(posedge pclk);
    chk("extra_req", 32'h0, {31'h0, mem_req});
    chk("run", 32'h1, {31'h0, run_active});
    chk("irq_done", 32'h1, {31'h0, irq});
    rdc(init_regs_pkg::off_main, mexp(1'b1, 1'b1, 1'b0, 4'h1, 4'h0), "main_done");
    apb(1'b1, init_regs_pkg::off_main, 32'h0000_0000);
    rdc(init_regs_pkg::off_main, mexp(1'b1, 1'b1, 1'b0, 4'h1, 4'h0), "main_w0_set");
    apb(1'b1, init_regs_pkg::off_mask, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, init_regs_pkg::off_addr_low, 32'h0);
    chk("lock_w", 32'h1, {31'h0, er});
    apb(1'b0, init_regs_pkg::off_addr_high, 32'h0);
    chk("lock_r", 32'h1, {31'h0, er});
    apb(1'b1, init_regs_pkg::off_main, 32'h0000_0004);
    rdc(init_regs_pkg::off_main, mexp(1'b0, 1'b0, 1'b1, 4'h1, 4'h1), "main_halt");
    rdc(init_regs_pkg::off_mask, 32'h0000_0100, "mask_halt");
    rdc(init_regs_pkg::off_addr_low, {16'h0, lo}, "lo_kept");
    apb(1'b1, init_regs_pkg::off_main, 32'h0);
    rdc(init_regs_pkg::off_main, mexp(1'b0, 1'b0, 1'b1, 4'h1, 4'h1), "main_w0");
    apb(1'b1, init_regs_pkg::off_main, 32'h0000_0007);
    rdc(init_regs_pkg::off_main, mexp(1'b0, 1'b0, 1'b1, 4'h1, 4'h1), "main_halt_wins");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(init_regs_pkg::off_mask, 32'h0, "mask_rst2");
    rdc(init_regs_pkg::off_addr_low, {16'h0, lo}, "lo_rst2");
    conclude;
  end
endmodule
